// ==== rtl/acn_pkg.sv ====
package acn_pkg;
    // Configuration register numbers
    localparam logic [7:0] REG_IDENT = 8'h00;
    localparam logic [7:0] REG_NODE_CFG = 8'h04;
    localparam logic [7:0] REG_NODE_NUM = 8'h05;
    localparam logic [7:0] REG_RMC = 8'h50;

    // Identification fields
    localparam int IDENT_CHIP_LSB = 24;
    localparam int IDENT_STRAP_BIT = 16;
    localparam int IDENT_REV_LSB = 8;
    localparam int IDENT_VER_LSB = 0;
    localparam int IDENT_FIELD_W = 8;

    // Header format and lock fields
    localparam int NCFG_LOCK_BIT = 31;
    localparam int NCFG_HDR_BIT = 0;

    // Node number field
    localparam int NODE_NUM_W = 16;
    localparam logic [NODE_NUM_W-1:0] NODE_NUM_RST = 16'h0000;

    // Reset and pin mode control fields
    localparam int RMC_SYS_BIT = 0;
    localparam int RMC_TILE_BIT = 1;
    localparam int RMC_USB_EN_BIT = 2;
    localparam int RMC_USB_ACC_BIT = 3;
    localparam int RMC_MODE_LSB = 16;
    localparam int MODE_W = 2;
    localparam int RMC_TRI_BIT = 24;
    localparam logic [MODE_W-1:0] MODE_PINS_RST = 2'h0;
    localparam logic TRISTATE_RST = 1'b1;

    // Reset durations in oscillator cycles
    localparam int SYS_RST_CYCLES_DEF = 524288;
    localparam int TILE_RST_CYCLES_DEF = 16;

    // Identity defaults, values arbitrary
    localparam logic [7:0] CHIP_ID_DEF = 8'hA5;
    localparam logic [7:0] ANA_REV_DEF = 8'h11;
    localparam logic [7:0] ANA_VER_DEF = 8'h03;
endpackage : acn_pkg

// ==== rtl/acn_rst_stretch.sv ====
`timescale 1ns/1ns
module acn_rst_stretch #(
    parameter int CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Trigger and stretched output
    input wire logic trig,
    output logic active_ff
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_ff;

    // Holds for CYCLES edges after the trigger is released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= ZERO;
            active_ff <= 1'b0;
        end else if (trig) begin
            cnt_ff <= LOAD;
            active_ff <= 1'b1;
        end else if (active_ff) begin
            if (cnt_ff == ZERO) begin
                active_ff <= 1'b0;
            end else begin
                cnt_ff <= cnt_ff - ONE;
            end
        end
    end
endmodule : acn_rst_stretch

// ==== rtl/acn_node_cfg.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Registers reached only through configuration packets
// - Identification read-only: chip, revision, version
// - Identification bit 16 shows oscillator strap
// - Lock bit blocks node configuration writes only
// - Bit 0 selects one- or three-byte headers
// - Sixteen-bit node number, resets to zero
// - Pin, brown-out or watchdog cause system reset
// - Sleep or clock change cause tile reset
// - System reset reaches outside; tile reset tiles only
// - System reset lasts fixed oscillator cycle count after its cause ends
// - Writing bit 1 starts self-clearing tile reset
// - Writing bit 0 starts self-clearing system reset
// - Reset-starting writes never send a response
// - Bit 2 enables USB; clear resets it
// - Bit 3 gates USB register access, resets off
// - Bits 17:16 drive mode pins; 24 tristates
module acn_node_cfg
    import acn_pkg::*;
#(
    parameter int SYS_RST_CYCLES = SYS_RST_CYCLES_DEF,
    parameter int TILE_RST_CYCLES = TILE_RST_CYCLES_DEF,
    parameter logic [7:0] CHIP_ID = CHIP_ID_DEF,
    parameter logic [7:0] ANA_REV = ANA_REV_DEF,
    parameter logic [7:0] ANA_VER = ANA_VER_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Configuration request from the switch
    input wire logic cfg_req_valid,
    input wire logic cfg_req_write,
    input wire logic cfg_req_want_resp,
    input wire logic [7:0] cfg_req_num,
    input wire logic [31:0] cfg_req_wdata,
    // Configuration response to the switch
    output logic cfg_rsp_valid_ff,
    output logic cfg_rsp_ack_ff,
    output logic [31:0] cfg_rsp_rdata_ff,
    // Reset sources and boot oscillator strap
    input wire logic ext_rst_pin_n,
    input wire logic brownout,
    input wire logic watchdog_expired,
    input wire logic sleep_seq,
    input wire logic clk_src_change,
    input wire logic boot_oscillator_strap,
    // Reset outputs
    output logic sys_reset_out_ff,
    output logic tile_reset_out_ff,
    // Node settings
    output logic hdr_one_byte_ff,
    output logic link_cfg_lock_ff,
    output logic [NODE_NUM_W-1:0] node_num_ff,
    // USB block control
    output logic usb_enable_ff,
    output logic usb_block_reset_ff,
    output logic usb_access_en_ff,
    // Processor mode pins
    output logic [MODE_W-1:0] mode_pin_out_ff,
    output logic [MODE_W-1:0] mode_pin_oe_ff
);
    localparam int NSYNC = 3;

    // Pin inputs: reset pin, brown-out, strap
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic rst_pin_low;
    logic brownout_s;
    logic strap_s;
    logic strap_cap_ff;
    logic sw_sys_ff;
    logic sw_tile_ff;
    logic sys_act;
    logic tile_act;
    logic sys_trig;
    logic tile_trig;
    logic wr_hit;
    logic rd_hit;
    logic mapped;
    logic [31:0] rd_data;
    logic [MODE_W-1:0] mode_val_ff;
    logic tristate_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {boot_oscillator_strap, brownout, ~ext_rst_pin_n};
            sync2_ff <= sync1_ff;
        end
    end

    assign rst_pin_low = sync2_ff[0];
    assign brownout_s = sync2_ff[1];
    assign strap_s = sync2_ff[2];

    // Requests are dropped while the bank is held in system reset
    assign wr_hit = cfg_req_valid && cfg_req_write && !sys_act;
    assign rd_hit = cfg_req_valid && !cfg_req_write && !sys_act;

    assign mapped = (cfg_req_num == REG_IDENT) || (cfg_req_num == REG_NODE_CFG) ||
                    (cfg_req_num == REG_NODE_NUM) || (cfg_req_num == REG_RMC);

    // Reset generation
    assign sys_trig = rst_pin_low || brownout_s || watchdog_expired || sw_sys_ff;
    assign tile_trig = sleep_seq || clk_src_change || sw_tile_ff;

    acn_rst_stretch #(
        .CYCLES(SYS_RST_CYCLES)
    ) u_sys_stretch (
        .clk(clk),
        .resetn(resetn),
        .trig(sys_trig),
        .active_ff(sys_act)
    );

    acn_rst_stretch #(
        .CYCLES(TILE_RST_CYCLES)
    ) u_tile_stretch (
        .clk(clk),
        .resetn(resetn),
        .trig(tile_trig),
        .active_ff(tile_act)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_reset_out_ff <= 1'b1;
            tile_reset_out_ff <= 1'b1;
        end else begin
            sys_reset_out_ff <= sys_act;
            tile_reset_out_ff <= tile_act || sys_act;
        end
    end

    // Self-clearing reset requests, one-cycle pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_sys_ff <= 1'b0;
            sw_tile_ff <= 1'b0;
        end else begin
            sw_sys_ff <= wr_hit && (cfg_req_num == REG_RMC) && cfg_req_wdata[RMC_SYS_BIT];
            sw_tile_ff <= wr_hit && (cfg_req_num == REG_RMC) &&
                          cfg_req_wdata[RMC_TILE_BIT];
        end
    end

    // Strap follows the pin only while system reset runs, then holds
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_cap_ff <= 1'b0;
        end else if (sys_act) begin
            strap_cap_ff <= strap_s;
        end
    end

    // Header format and lock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hdr_one_byte_ff <= 1'b0;
            link_cfg_lock_ff <= 1'b0;
        end else if (sys_act) begin
            hdr_one_byte_ff <= 1'b0;
            link_cfg_lock_ff <= 1'b0;
        end else if (wr_hit && cfg_req_num == REG_NODE_CFG && !link_cfg_lock_ff) begin
            hdr_one_byte_ff <= cfg_req_wdata[NCFG_HDR_BIT];
            link_cfg_lock_ff <= cfg_req_wdata[NCFG_LOCK_BIT];
        end
    end

    // Node number
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            node_num_ff <= NODE_NUM_RST;
        end else if (sys_act) begin
            node_num_ff <= NODE_NUM_RST;
        end else if (wr_hit && cfg_req_num == REG_NODE_NUM) begin
            node_num_ff <= cfg_req_wdata[NODE_NUM_W-1:0];
        end
    end

    // USB enables and mode pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            usb_enable_ff <= 1'b0;
            usb_access_en_ff <= 1'b0;
            mode_val_ff <= MODE_PINS_RST;
            tristate_ff <= TRISTATE_RST;
        end else if (sys_act) begin
            usb_enable_ff <= 1'b0;
            usb_access_en_ff <= 1'b0;
            mode_val_ff <= MODE_PINS_RST;
            tristate_ff <= TRISTATE_RST;
        end else if (wr_hit && cfg_req_num == REG_RMC) begin
            usb_enable_ff <= cfg_req_wdata[RMC_USB_EN_BIT];
            usb_access_en_ff <= cfg_req_wdata[RMC_USB_ACC_BIT];
            mode_val_ff <= cfg_req_wdata[RMC_MODE_LSB +: MODE_W];
            tristate_ff <= cfg_req_wdata[RMC_TRI_BIT];
        end
    end

    // Pin outputs lag their register copies by one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            usb_block_reset_ff <= 1'b1;
            mode_pin_out_ff <= MODE_PINS_RST;
            mode_pin_oe_ff <= {MODE_W{~TRISTATE_RST}};
        end else begin
            usb_block_reset_ff <= !usb_enable_ff;
            mode_pin_out_ff <= mode_val_ff;
            mode_pin_oe_ff <= {MODE_W{~tristate_ff}};
        end
    end

    // Read data; reserved and self-clearing bits read zero
    always_comb begin
        rd_data = '0;
        if (cfg_req_num == REG_IDENT) begin
            rd_data[IDENT_CHIP_LSB +: IDENT_FIELD_W] = CHIP_ID;
            rd_data[IDENT_STRAP_BIT] = strap_cap_ff;
            rd_data[IDENT_REV_LSB +: IDENT_FIELD_W] = ANA_REV;
            rd_data[IDENT_VER_LSB +: IDENT_FIELD_W] = ANA_VER;
        end else if (cfg_req_num == REG_NODE_CFG) begin
            rd_data[NCFG_LOCK_BIT] = link_cfg_lock_ff;
            rd_data[NCFG_HDR_BIT] = hdr_one_byte_ff;
        end else if (cfg_req_num == REG_NODE_NUM) begin
            rd_data[NODE_NUM_W-1:0] = node_num_ff;
        end else if (cfg_req_num == REG_RMC) begin
            rd_data[RMC_USB_EN_BIT] = usb_enable_ff;
            rd_data[RMC_USB_ACC_BIT] = usb_access_en_ff;
            rd_data[RMC_MODE_LSB +: MODE_W] = mode_val_ff;
            rd_data[RMC_TRI_BIT] = tristate_ff;
        end
    end

    // Response: reads always answer, writes only when asked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rsp_valid_ff <= 1'b0;
            cfg_rsp_ack_ff <= 1'b0;
            cfg_rsp_rdata_ff <= '0;
        end else begin
            cfg_rsp_valid_ff <= 1'b0;
            cfg_rsp_ack_ff <= 1'b0;
            cfg_rsp_rdata_ff <= '0;
            if (rd_hit) begin
                cfg_rsp_valid_ff <= 1'b1;
                cfg_rsp_ack_ff <= mapped;
                cfg_rsp_rdata_ff <= rd_data;
            end else if (wr_hit && cfg_req_want_resp) begin
                if (cfg_req_num == REG_RMC &&
                    (cfg_req_wdata[RMC_SYS_BIT] || cfg_req_wdata[RMC_TILE_BIT])) begin
                    cfg_rsp_valid_ff <= 1'b0;
                end else begin
                    cfg_rsp_valid_ff <= 1'b1;
                    // Identification and locked writes are refused
                    cfg_rsp_ack_ff <= mapped && (cfg_req_num != REG_IDENT) &&
                        !(cfg_req_num == REG_NODE_CFG && link_cfg_lock_ff);
                end
            end
        end
    end

    property p_ident_read;
        @(posedge clk) disable iff (!resetn)
        rd_hit && cfg_req_num == REG_IDENT |=> cfg_rsp_valid_ff && cfg_rsp_ack_ff &&
            cfg_rsp_rdata_ff[31:24] == CHIP_ID && cfg_rsp_rdata_ff[23:17] == 7'h00 &&
            cfg_rsp_rdata_ff[15:8] == ANA_REV && cfg_rsp_rdata_ff[7:0] == ANA_VER;
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("ident read wrong");

    property p_strap_hold;
        @(posedge clk) disable iff (!resetn)
        !sys_act && $past(!sys_act) |-> $stable(strap_cap_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

    property p_lock_blocks;
        @(posedge clk) disable iff (!resetn)
        link_cfg_lock_ff && !sys_act && wr_hit && cfg_req_num == REG_NODE_CFG
            |=> $stable(hdr_one_byte_ff) && link_cfg_lock_ff;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("lock broken");

    property p_lock_sticky;
        @(posedge clk) disable iff (!resetn)
        link_cfg_lock_ff && !sys_act |=> link_cfg_lock_ff;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

    property p_hdr_write;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_NODE_CFG && !link_cfg_lock_ff
            |=> hdr_one_byte_ff == $past(cfg_req_wdata[NCFG_HDR_BIT]);
    endproperty
    a_hdr_write: assert property (p_hdr_write) else $error("header bit not written");

    property p_no_rsp_reset_wr;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_RMC &&
            (cfg_req_wdata[RMC_SYS_BIT] || cfg_req_wdata[RMC_TILE_BIT]) |=> !cfg_rsp_valid_ff;
    endproperty
    a_no_rsp_reset_wr: assert property (p_no_rsp_reset_wr) else $error("reset write answered");

    property p_sw_sys_reset;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_RMC && cfg_req_wdata[RMC_SYS_BIT]
            |-> ##[2:3] sys_reset_out_ff ##1 sys_reset_out_ff && tile_reset_out_ff;
    endproperty
    a_sw_sys_reset: assert property (p_sw_sys_reset) else $error("no system reset");

    property p_pin_reset;
        @(posedge clk) disable iff (!resetn)
        !ext_rst_pin_n [*3] |-> ##[1:3] sys_reset_out_ff;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

    property p_sw_tile_reset;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_RMC && cfg_req_wdata[RMC_TILE_BIT]
            |-> ##[2:3] tile_reset_out_ff;
    endproperty
    a_sw_tile_reset: assert property (p_sw_tile_reset) else $error("no tile reset");

    property p_usb_disable;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_RMC && !cfg_req_wdata[RMC_USB_EN_BIT]
            |-> ##2 usb_block_reset_ff;
    endproperty
    a_usb_disable: assert property (p_usb_disable) else $error("usb not reset");

    property p_reserved_zero;
        @(posedge clk) disable iff (!resetn)
        rd_hit && cfg_req_num == REG_NODE_NUM |=> cfg_rsp_rdata_ff[31:16] == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero");

    property p_unmapped_nack;
        @(posedge clk) disable iff (!resetn)
        rd_hit && !mapped |=> cfg_rsp_valid_ff && !cfg_rsp_ack_ff;
    endproperty
    a_unmapped_nack: assert property (p_unmapped_nack) else $error("unmapped acked");

    property p_mode_pins;
        @(posedge clk) disable iff (!resetn)
        wr_hit && cfg_req_num == REG_RMC |-> ##2
            mode_pin_out_ff == $past(cfg_req_wdata[RMC_MODE_LSB +: MODE_W], 2) &&
            mode_pin_oe_ff == {MODE_W{!$past(cfg_req_wdata[RMC_TRI_BIT], 2)}};
    endproperty
    a_mode_pins: assert property (p_mode_pins) else $error("mode pins wrong");

    c_lock_set: cover property (@(posedge clk) disable iff (!resetn)
        $rose(link_cfg_lock_ff));
    c_sys_done: cover property (@(posedge clk) disable iff (!resetn)
        $fell(sys_reset_out_ff));
    c_tile_only: cover property (@(posedge clk) disable iff (!resetn)
        tile_reset_out_ff && !sys_reset_out_ff);
    c_usb_on: cover property (@(posedge clk) disable iff (!resetn)
        $rose(usb_enable_ff));
endmodule : acn_node_cfg

// ==== tb/acn_tile_model.sv ====
`timescale 1ns/1ns
module acn_tile_model (
    // Clock
    input wire logic clk,
    // Request to the node
    output logic req_valid,
    output logic req_write,
    output logic req_want_resp,
    output logic [7:0] req_num,
    output logic [31:0] req_wdata,
    // Response from the node
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    input wire logic [31:0] rsp_rdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_want_resp = 1'b0;
        req_num = 8'hFF;
        req_wdata = 32'h0;
    end

    // One strobe per word; idle lines inverted so stale values never match
    task automatic xfer(input logic wr, input logic want, input logic [7:0] num,
        input logic [31:0] wd, output logic got, output logic ack, output logic [31:0] rd);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_want_resp <= want;
        req_num <= num;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        req_write <= ~wr;
        req_want_resp <= ~want;
        req_num <= ~num;
        req_wdata <= ~wd;
        @(negedge clk);
        got = rsp_valid;
        ack = rsp_ack;
        rd = rsp_rdata;
    endtask : xfer
endmodule : acn_tile_model

// ==== tb/analog_node_config_and_reset_tb.sv ====
`timescale 1ns/1ns
module analog_node_config_and_reset_tb;
    import acn_pkg::*;
    localparam int SYS_N = 8;
    logic clk, resetn, rq_v, rq_w, rq_r, rs_v, rs_a;
    logic [7:0] rq_n;
    logic [31:0] rq_d, rs_d, w;
    logic ext_rst_pin_n, brownout, watchdog_expired, sleep_seq, clk_src_change, strap;
    logic sys_reset_out_ff, tile_reset_out_ff, hdr_one_byte_ff, link_cfg_lock_ff;
    logic usb_enable_ff, usb_block_reset_ff, usb_access_en_ff;
    logic [NODE_NUM_W-1:0] node_num_ff;
    logic [MODE_W-1:0] mode_pin_out_ff, mode_pin_oe_ff;
    int fail_count, checks, n;

    acn_node_cfg #(.SYS_RST_CYCLES(SYS_N), .TILE_RST_CYCLES(4)) u_dut (
        .clk(clk), .resetn(resetn),
        .cfg_req_valid(rq_v), .cfg_req_write(rq_w), .cfg_req_want_resp(rq_r),
        .cfg_req_num(rq_n), .cfg_req_wdata(rq_d),
        .cfg_rsp_valid_ff(rs_v), .cfg_rsp_ack_ff(rs_a), .cfg_rsp_rdata_ff(rs_d),
        .ext_rst_pin_n(ext_rst_pin_n), .brownout(brownout),
        .watchdog_expired(watchdog_expired), .sleep_seq(sleep_seq),
        .clk_src_change(clk_src_change), .boot_oscillator_strap(strap),
        .sys_reset_out_ff(sys_reset_out_ff), .tile_reset_out_ff(tile_reset_out_ff),
        .hdr_one_byte_ff(hdr_one_byte_ff), .link_cfg_lock_ff(link_cfg_lock_ff),
        .node_num_ff(node_num_ff), .usb_enable_ff(usb_enable_ff),
        .usb_block_reset_ff(usb_block_reset_ff), .usb_access_en_ff(usb_access_en_ff),
        .mode_pin_out_ff(mode_pin_out_ff), .mode_pin_oe_ff(mode_pin_oe_ff)
    );

    acn_tile_model u_tile (
        .clk(clk), .req_valid(rq_v), .req_write(rq_w), .req_want_resp(rq_r),
        .req_num(rq_n), .req_wdata(rq_d),
        .rsp_valid(rs_v), .rsp_ack(rs_a), .rsp_rdata(rs_d)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] ident(input logic s);
        return {CHIP_ID_DEF, 7'h00, s, ANA_REV_DEF, ANA_VER_DEF};
    endfunction : ident

    task automatic report_and_stop;
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic rd_chk(input logic [7:0] a, input logic k, input logic [31:0] e);
        logic g, ack;
        logic [31:0] d;
        u_tile.xfer(1'b0, 1'b1, a, 32'h0, g, ack, d);
        chk32("rd_resp", 32'h1, 32'(g));
        chk32("rd_ack", 32'(k), 32'(ack));
        chk32("rd_data", e, d);
    endtask : rd_chk

    task automatic wr_do(input logic [7:0] a, input logic [31:0] v, input logic want,
        input logic eg, input logic ek);
        logic g, ack;
        logic [31:0] d;
        u_tile.xfer(1'b1, want, a, v, g, ack, d);
        chk32("wr_resp", 32'(eg), 32'(g));
        if (eg) chk32("wr_ack", 32'(ek), 32'(ack));
    endtask : wr_do

    task automatic drive(input int s, input logic on);
        case (s)
            0: ext_rst_pin_n <= ~on;
            1: brownout <= on;
            2: watchdog_expired <= on;
            3: sleep_seq <= on;
            default: clk_src_change <= on;
        endcase
    endtask : drive

    task automatic pulse(input int s);
        @(posedge clk);
        drive(s, 1'b1);
        repeat (3) @(posedge clk);
        drive(s, 1'b0);
    endtask : pulse

    // Bounded wait on a reset output; n counts the cycles spent
    task automatic wait_for(input int sel, input logic v, output int c);
        logic sig;
        c = 0;
        do begin
            @(negedge clk);
            sig = (sel == 0) ? sys_reset_out_ff : tile_reset_out_ff;
            c++;
        end while (sig !== v && c < 40);
        if (sig !== v) begin
            fail_count++;
            $display("mismatch reset_level expected %b seen %b", v, sig);
            report_and_stop();
        end
    endtask : wait_for

    initial begin
        resetn = 1'b0;
        ext_rst_pin_n = 1'b1;
        brownout = 1'b0;
        watchdog_expired = 1'b0;
        sleep_seq = 1'b0;
        clk_src_change = 1'b0;
        strap = 1'b0;
        fail_count = 0;
        checks = 0;
        void'($urandom(32'hb18f));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        rd_chk(REG_NODE_CFG, 1'b1, 32'h0);
        rd_chk(REG_NODE_NUM, 1'b1, 32'h0);
        rd_chk(REG_RMC, 1'b1, 32'h0100_0000);
        chk32("usb_block_reset", 32'h1, 32'(usb_block_reset_ff));
        // Pin, brown-out, watchdog; strap is latched during each reset
        for (int s = 0; s < 3; s++) begin
            wr_do(REG_NODE_NUM, 32'h0000_1234, 1'b1, 1'b1, 1'b1);
            strap <= s[0];
            pulse(s);
            wait_for(0, 1'b1, n);
            chk32("tile_in_sys", 32'h1, 32'(tile_reset_out_ff));
            wait_for(0, 1'b0, n);
            rd_chk(REG_NODE_NUM, 1'b1, 32'h0);
            rd_chk(REG_IDENT, 1'b1, ident(s[0]));
        end
        wr_do(REG_IDENT, $urandom, 1'b1, 1'b1, 1'b0);
        rd_chk(8'h33, 1'b0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            w[31] = 1'b0;
            wr_do(REG_NODE_CFG, w, 1'b1, 1'b1, 1'b1);
            rd_chk(REG_NODE_CFG, 1'b1, w & 32'h1);
            chk32("hdr_one_byte", 32'(w[0]), 32'(hdr_one_byte_ff));
            w = $urandom;
            wr_do(REG_NODE_NUM, w, i[0], i[0], 1'b1);
            rd_chk(REG_NODE_NUM, 1'b1, w & 32'hFFFF);
            chk32("node_num", w & 32'hFFFF, 32'(node_num_ff));
            w = $urandom & 32'hFFFF_FFFC;
            wr_do(REG_RMC, w, 1'b1, 1'b1, 1'b1);
            rd_chk(REG_RMC, 1'b1, w & 32'h0103_000C);
            chk32("usb_enable", 32'(w[2]), 32'(usb_enable_ff));
            chk32("usb_block_reset", 32'(!w[2]), 32'(usb_block_reset_ff));
            chk32("usb_access", 32'(w[3]), 32'(usb_access_en_ff));
            chk32("mode_out", 32'(w[17:16]), 32'(mode_pin_out_ff));
            chk32("mode_oe", 32'(w[24] ? 2'b00 : 2'b11), 32'(mode_pin_oe_ff));
        end
        // Lock, then a software system reset must free it
        wr_do(REG_NODE_CFG, 32'h8000_0001, 1'b1, 1'b1, 1'b1);
        wr_do(REG_NODE_CFG, 32'h0, 1'b1, 1'b1, 1'b0);
        rd_chk(REG_NODE_CFG, 1'b1, 32'h8000_0001);
        chk32("lock", 32'h1, 32'(link_cfg_lock_ff));
        wr_do(REG_RMC, 32'h0000_0001, 1'b1, 1'b0, 1'b0);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        chk32("sys_len", 32'(SYS_N), 32'(n));
        rd_chk(REG_NODE_CFG, 1'b1, 32'h0);
        chk32("lock", 32'h0, 32'(link_cfg_lock_ff));
        // Sleep, clock change, software tile reset
        for (int s = 3; s < 6; s++) begin
            if (s == 5) wr_do(REG_RMC, 32'h0000_0002, 1'b1, 1'b0, 1'b0);
            else pulse(s);
            wait_for(1, 1'b1, n);
            chk32("sys_quiet", 32'h0, 32'(sys_reset_out_ff));
            wait_for(1, 1'b0, n);
        end
        // Last write cleared the tristate bit; tile request bit reads back zero
        rd_chk(REG_RMC, 1'b1, 32'h0000_0000);
        report_and_stop();
    end
endmodule : analog_node_config_and_reset_tb
